// File: dsc_config_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Comm bit 7 makes data pin bidirectional.
// - Comm bit 6 chooses LSB-first serial order.
// - Writing 1 then 0 resets register map.
// - Comm bit 4 powers down all but port.
// - Comm bit 3 allows automatic power-down.
// - Comm bit 1 reads PLL lock, read-only.
// - Reg 1 bits 5:2 pick filter mode.
// - Reg 1 bit 1 is data clock delay MSB.
// - Reg 1 bit 0 enables zero stuffing.
// - Reg 2 bit 6 feeds both converters port one.
// - Reg 2 bit 5 shuts off Q path.
// - Reg 2 bit 4 enables data clock delay.
// - Reg 2 bit 3 inserts inverse-sinc filter.
// - Reg 2 bit 2 inverts output data clock.
// - Reg 2 bit 1 inverts transmit-enable pin.
// - Reg 2 bit 0 puts Q word first.

module dsc_config_regs (
    // Clock, reset and freeze
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Register access from the serial port engine
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Pins and core status
    input wire logic pll_locked_pin,
    input wire logic transmit_enable_pin,
    input wire logic auto_pd_request,
    // Serial port configuration
    output logic sdio_bidir,
    output logic lsb_first,
    output logic soft_reset_pulse,
    // Power control
    output logic power_down,
    output logic auto_pd_enable,
    output logic core_power_down,
    // Datapath configuration
    output dsc_pkg::dsc_interp_t interp_factor,
    output logic [3:0] filter_mode,
    output logic data_clock_delay_msb,
    output logic zero_stuff_en,
    output logic unsigned_format,
    output logic single_port,
    output logic real_mode,
    output logic data_clock_delay_en,
    output logic inv_sinc_en,
    output logic data_clock_invert,
    output logic txen_invert,
    output logic q_first,
    // Transmit enable after polarity, also the I/Q select
    output logic tx_enable
);

    dsc_pkg::dsc_state_t state_ff;
    dsc_pkg::dsc_state_t nxt_state;
    dsc_pkg::dsc_req_t req;
    logic pll_locked_sync;
    logic txen_sync;
    logic soft_reset_hit;

    // Both pins come from outside the clock domain
    dsc_sync #(
        .WIDTH(2),
        .STAGES(dsc_pkg::SYNC_STAGES)
    ) u_pin_sync (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .async_in({pll_locked_pin, transmit_enable_pin}),
        .sync_out({pll_locked_sync, txen_sync})
    );

    // Read value of one register; lock status is live, not stored
    function automatic logic [7:0] read_reg(
        input logic [4:0] addr,
        input logic [7:0] comm,
        input logic [7:0] dpa,
        input logic [7:0] dpb,
        input logic locked
    );
        logic [7:0] value;
        value = dsc_pkg::UNMAPPED_READ_DATA;
        unique case (addr)
            dsc_pkg::OFS_SERIAL_COMM_CONFIG: begin
                value = comm & dsc_pkg::COMM_WRITE_MASK;
                value[dsc_pkg::COMM_PLL_LOCK_BIT] = locked;
            end
            dsc_pkg::OFS_DATAPATH_CONFIG_A: begin
                value = dpa;
            end
            dsc_pkg::OFS_DATAPATH_CONFIG_B: begin
                value = dpb;
            end
            default: begin
                value = dsc_pkg::UNMAPPED_READ_DATA;
            end
        endcase
        return value;
    endfunction

    // A write reaches the register only at its own offset
    function automatic logic write_hit(
        input dsc_pkg::dsc_req_t r,
        input logic [4:0] offset
    );
        return r.wr_en && (r.addr == offset);
    endfunction

    always_comb begin
        req.wr_en = reg_wr_en;
        req.rd_en = reg_rd_en;
        req.addr = reg_addr;
        req.wdata = reg_wdata;
    end

    // The falling write of the reset bit is what restores the map
    always_comb begin
        soft_reset_hit = write_hit(req, dsc_pkg::OFS_SERIAL_COMM_CONFIG)
            && state_ff.comm[dsc_pkg::COMM_SOFT_RESET_BIT]
            && !req.wdata[dsc_pkg::COMM_SOFT_RESET_BIT];
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rd_valid = 1'b0;
        nxt_state.soft_reset_pulse = 1'b0;

        // Read-only lock bit and unused bits are masked off on write
        if (write_hit(req, dsc_pkg::OFS_SERIAL_COMM_CONFIG)) begin
            nxt_state.comm = req.wdata & dsc_pkg::COMM_WRITE_MASK;
        end
        if (write_hit(req, dsc_pkg::OFS_DATAPATH_CONFIG_A)) begin
            nxt_state.dpa = req.wdata;
        end
        if (write_hit(req, dsc_pkg::OFS_DATAPATH_CONFIG_B)) begin
            nxt_state.dpb = req.wdata;
        end

        if (soft_reset_hit) begin
            nxt_state.comm = dsc_pkg::RST_SERIAL_COMM_CONFIG;
            nxt_state.dpa = dsc_pkg::RST_DATAPATH_CONFIG_A;
            nxt_state.dpb = dsc_pkg::RST_DATAPATH_CONFIG_B;
            nxt_state.soft_reset_pulse = 1'b1;
        end

        // Read shows state before a write in the same cycle
        if (req.rd_en) begin
            nxt_state.rd_data = read_reg(req.addr, state_ff.comm, state_ff.dpa, state_ff.dpb, pll_locked_sync);
            nxt_state.rd_valid = 1'b1;
        end

        // Auto power-down only acts while software has allowed it
        nxt_state.core_power_down = nxt_state.comm[dsc_pkg::COMM_POWER_DOWN_BIT]
            || (nxt_state.comm[dsc_pkg::COMM_AUTO_PD_EN_BIT] && auto_pd_request);

        // Pin polarity applied here so the core sees one sense
        nxt_state.tx_enable = txen_sync ^ nxt_state.dpb[dsc_pkg::DPB_TXEN_INVERT_BIT];
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_ff.comm <= dsc_pkg::RST_SERIAL_COMM_CONFIG;
            state_ff.dpa <= dsc_pkg::RST_DATAPATH_CONFIG_A;
            state_ff.dpb <= dsc_pkg::RST_DATAPATH_CONFIG_B;
            state_ff.rd_data <= dsc_pkg::RST_READ_DATA;
            state_ff.rd_valid <= 1'b0;
            state_ff.soft_reset_pulse <= 1'b0;
            state_ff.core_power_down <= 1'b0;
            state_ff.tx_enable <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Register read port
    assign reg_rdata = state_ff.rd_data;
    assign reg_rvalid = state_ff.rd_valid;

    // Serial port configuration
    assign sdio_bidir = state_ff.comm[dsc_pkg::COMM_SDIO_BIDIR_BIT];
    assign lsb_first = state_ff.comm[dsc_pkg::COMM_LSB_FIRST_BIT];
    assign soft_reset_pulse = state_ff.soft_reset_pulse;

    // Power control; the serial port itself never powers down
    assign power_down = state_ff.comm[dsc_pkg::COMM_POWER_DOWN_BIT];
    assign auto_pd_enable = state_ff.comm[dsc_pkg::COMM_AUTO_PD_EN_BIT];
    assign core_power_down = state_ff.core_power_down;

    // Datapath configuration A
    assign interp_factor = dsc_pkg::dsc_interp_t'(
        state_ff.dpa[dsc_pkg::DPA_INTERP_MSB:dsc_pkg::DPA_INTERP_LSB]);
    assign filter_mode = state_ff.dpa[dsc_pkg::DPA_FILTER_MODE_MSB:dsc_pkg::DPA_FILTER_MODE_LSB];
    assign data_clock_delay_msb = state_ff.dpa[dsc_pkg::DPA_DCLK_DELAY_MSB_BIT];
    assign zero_stuff_en = state_ff.dpa[dsc_pkg::DPA_ZERO_STUFF_BIT];

    // Datapath configuration B
    assign unsigned_format = state_ff.dpb[dsc_pkg::DPB_UNSIGNED_BIT];
    assign single_port = state_ff.dpb[dsc_pkg::DPB_SINGLE_PORT_BIT];
    assign real_mode = state_ff.dpb[dsc_pkg::DPB_REAL_MODE_BIT];
    assign data_clock_delay_en = state_ff.dpb[dsc_pkg::DPB_DCLK_DELAY_EN_BIT];
    assign inv_sinc_en = state_ff.dpb[dsc_pkg::DPB_INV_SINC_EN_BIT];
    assign data_clock_invert = state_ff.dpb[dsc_pkg::DPB_DCLK_INVERT_BIT];
    assign txen_invert = state_ff.dpb[dsc_pkg::DPB_TXEN_INVERT_BIT];
    assign q_first = state_ff.dpb[dsc_pkg::DPB_Q_FIRST_BIT];

    // Transmit enable after polarity
    assign tx_enable = state_ff.tx_enable;

endmodule

`default_nettype wire

// File: dsc_pkg.sv
package dsc_pkg;

    // Register offsets on the serial configuration port
    localparam logic [4:0] OFS_SERIAL_COMM_CONFIG = 5'h00;
    localparam logic [4:0] OFS_DATAPATH_CONFIG_A = 5'h01;
    localparam logic [4:0] OFS_DATAPATH_CONFIG_B = 5'h02;

    // Serial communication register fields
    localparam int COMM_SDIO_BIDIR_BIT = 7;
    localparam int COMM_LSB_FIRST_BIT = 6;
    localparam int COMM_SOFT_RESET_BIT = 5;
    localparam int COMM_POWER_DOWN_BIT = 4;
    localparam int COMM_AUTO_PD_EN_BIT = 3;
    localparam int COMM_PLL_LOCK_BIT = 1;

    // Bits that software can store in the communication register
    localparam logic [7:0] COMM_WRITE_MASK = 8'hF8;

    // Datapath configuration register A fields
    localparam int DPA_INTERP_MSB = 7;
    localparam int DPA_INTERP_LSB = 6;
    localparam int DPA_FILTER_MODE_MSB = 5;
    localparam int DPA_FILTER_MODE_LSB = 2;
    localparam int DPA_DCLK_DELAY_MSB_BIT = 1;
    localparam int DPA_ZERO_STUFF_BIT = 0;

    // Datapath configuration register B fields
    localparam int DPB_UNSIGNED_BIT = 7;
    localparam int DPB_SINGLE_PORT_BIT = 6;
    localparam int DPB_REAL_MODE_BIT = 5;
    localparam int DPB_DCLK_DELAY_EN_BIT = 4;
    localparam int DPB_INV_SINC_EN_BIT = 3;
    localparam int DPB_DCLK_INVERT_BIT = 2;
    localparam int DPB_TXEN_INVERT_BIT = 1;
    localparam int DPB_Q_FIRST_BIT = 0;

    // Values after reset (registers also after a software reset) and on unmapped reads
    localparam logic [7:0] RST_SERIAL_COMM_CONFIG = 8'h00;
    localparam logic [7:0] RST_DATAPATH_CONFIG_A = 8'h00;
    localparam logic [7:0] RST_DATAPATH_CONFIG_B = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_DATA = 8'h00;

    // Flip-flops in front of any pin input
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        DSC_INTERP_1X = 2'h0,
        DSC_INTERP_2X = 2'h1,
        DSC_INTERP_4X = 2'h2,
        DSC_INTERP_8X = 2'h3
    } dsc_interp_t;

    // Request from the serial port engine, same clock
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [4:0] addr;
        logic [7:0] wdata;
    } dsc_req_t;

    // Full state of the register bank
    typedef struct packed {
        logic [7:0] comm;
        logic [7:0] dpa;
        logic [7:0] dpb;
        logic [7:0] rd_data;
        logic rd_valid;
        logic soft_reset_pulse;
        logic core_power_down;
        logic tx_enable;
    } dsc_state_t;

endpackage

// File: dsc_sync.sv
`timescale 1ns/100ps
`default_nettype none

module dsc_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = dsc_pkg::SYNC_STAGES
) (
    // Clock and control
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] chain;
    } dsc_sync_state_t;

    dsc_sync_state_t state_ff;
    dsc_sync_state_t nxt_state;

    // Refused at elaboration: one stage would let logic read a metastable bit
    if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
        $error("dsc_sync needs at least two stages and one bit");
    end

    // First stage feeds only the second stage
    always_comb begin
        nxt_state = state_ff;
        nxt_state.chain = {state_ff.chain[STAGES-2:0], async_in};
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.chain[STAGES-1];

endmodule

`default_nettype wire

// File: dsc_props.sv
`timescale 1ns/100ps
`default_nettype none
module dsc_props (
    // Clock and register port
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Configuration outputs
    input wire logic sdio_bidir,
    input wire logic lsb_first,
    input wire logic soft_reset_pulse,
    input wire logic power_down,
    input wire logic auto_pd_enable,
    input wire logic core_power_down,
    input wire dsc_pkg::dsc_interp_t interp_factor,
    input wire logic zero_stuff_en,
    input wire logic txen_invert,
    input wire logic q_first
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Bit 5 set keeps a comm write clear of the soft reset path
    logic w0, w1, w2;
    assign w0 = ce && reg_wr_en && reg_addr == 5'h00 && reg_wdata[5];
    assign w1 = ce && reg_wr_en && reg_addr == 5'h01;
    assign w2 = ce && reg_wr_en && reg_addr == 5'h02;
    comm_read_a: assert property (ce && reg_rd_en && reg_addr == 5'h00 |=> reg_rvalid && reg_rdata[2] == 1'b0 && reg_rdata[0] == 1'b0) else $error("comm readback bad");
    pin_dir_a: assert property (w0 |=> sdio_bidir == $past(reg_wdata[7])) else $error("direction bit bad");
    bit_order_a: assert property (w0 |=> lsb_first == $past(reg_wdata[6])) else $error("order bit bad");
    pd_force_a: assert property (power_down |-> core_power_down) else $error("power down not applied");
    auto_pd_a: assert property (w0 |=> auto_pd_enable == $past(reg_wdata[3])) else $error("auto pd bit bad");
    pd_idle_a: assert property (!power_down && !auto_pd_enable |-> !core_power_down) else $error("spurious power down");
    soft_clear_a: assert property ($rose(soft_reset_pulse) |-> !sdio_bidir && !q_first && interp_factor == dsc_pkg::DSC_INTERP_1X) else $error("soft reset left state");
    dpa_write_a: assert property (w1 |=> interp_factor == $past(reg_wdata[7:6]) && zero_stuff_en == $past(reg_wdata[0])) else $error("reg a bad");
    dpb_write_a: assert property (w2 |=> q_first == $past(reg_wdata[0]) && txen_invert == $past(reg_wdata[1])) else $error("reg b bad");
endmodule
bind dsc_config_regs dsc_props u_props (.clock(clock), .rst_b(rst_b), .ce(ce), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sdio_bidir(sdio_bidir), .lsb_first(lsb_first), .soft_reset_pulse(soft_reset_pulse),
    .power_down(power_down), .auto_pd_enable(auto_pd_enable), .core_power_down(core_power_down),
    .interp_factor(interp_factor), .zero_stuff_en(zero_stuff_en), .txen_invert(txen_invert), .q_first(q_first));
`default_nettype wire

// File: dsc_host.sv
`timescale 1ns/100ps
`default_nettype none
module dsc_host (
    // Clock
    input wire logic clock,
    // Register port
    output logic wr_en,
    output logic rd_en,
    output logic [4:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
    end
    // Released lines show the inverse so stale values never pass
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask
    task soft_reset;
        wr(5'h00, 8'h20);
        wr(5'h00, 8'h00);
    endtask
    task rd(input logic [4:0] a, output logic [7:0] d);
        int i;
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
        d = 8'hXX;
        for (i = 0; i < 4; i++) begin
            @(posedge clock);
            if (rvalid === 1'b1) begin
                d = rdata;
                break;
            end
        end
        #1;
    endtask
endmodule
`default_nettype wire

// File: dsc_config_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dsc_config_regs_tb_top;
    logic clock, rst_b, ce, wr_en, rd_en, pll_pin, txen_pin, pd_req, rvalid;
    logic [4:0] addr;
    logic [7:0] wdata, rdata;
    logic bidir, lsbf, srp, pd, apd, cpd, dmsb, zs, uf, sp, rm, de, isinc, dinv, tinv, qf, txen;
    logic [3:0] fm;
    dsc_pkg::dsc_interp_t interp;
    int n_mismatch = 0;
    int check_count = 0;
    dsc_host h (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
        .rvalid(rvalid));
    dsc_config_regs DUT (.clock(clock), .rst_b(rst_b), .ce(ce), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .pll_locked_pin(pll_pin),
        .transmit_enable_pin(txen_pin), .auto_pd_request(pd_req), .sdio_bidir(bidir), .lsb_first(lsbf),
        .soft_reset_pulse(srp), .power_down(pd), .auto_pd_enable(apd), .core_power_down(cpd),
        .interp_factor(interp), .filter_mode(fm), .data_clock_delay_msb(dmsb), .zero_stuff_en(zs),
        .unsigned_format(uf), .single_port(sp), .real_mode(rm), .data_clock_delay_en(de), .inv_sinc_en(isinc),
        .data_clock_invert(dinv), .txen_invert(tinv), .q_first(qf), .tx_enable(txen));
    always #5 clock = ~clock;
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task test_done;
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task t_defaults;
        logic [7:0] d;
        h.rd(5'h00, d); chk("comm", 8'h00, d);
        h.rd(5'h01, d); chk("cfg_a", 8'h00, d);
        h.rd(5'h02, d); chk("cfg_b", 8'h00, d);
        h.rd(5'h1F, d); chk("unmapped", 8'h00, d);
    endtask
    task t_comm;
        logic [7:0] d;
        @(posedge clock);
        pll_pin <= 1'b1;
        pd_req <= 1'b1;
        h.wr(5'h00, 8'hEF);
        h.rd(5'h00, d); chk("comm", 8'hEA, d);
        chk("comm_out", 8'h1B, {3'h0, bidir, lsbf, pd, apd, cpd});
        @(posedge clock);
        pd_req <= 1'b0;
        h.wr(5'h00, 8'h30);
        chk("pd_out", 8'h03, {6'h00, pd, cpd});
    endtask
    task t_soft;
        logic [7:0] d;
        h.wr(5'h01, 8'hC1);
        h.wr(5'h02, 8'hFF);
        h.soft_reset();
        chk("soft_pulse", 8'h01, {7'h00, srp});
        h.rd(5'h01, d); chk("cfg_a", 8'h00, d);
        h.rd(5'h02, d); chk("cfg_b", 8'h00, d);
        h.rd(5'h00, d); chk("comm", 8'h02, d);
        h.wr(5'h01, 8'h40);
        h.wr(5'h00, 8'h00);
        h.rd(5'h01, d); chk("cfg_a", 8'h40, d);
        chk("soft_pulse", 8'h00, {7'h00, srp});
    endtask
    task t_cfg_a;
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            v = 8'(k * 8'h55);
            h.wr(5'h01, v);
            chk("cfg_a_out", v, {interp, fm, dmsb, zs});
        end
    endtask
    task t_cfg_b;
        for (int i = 0; i < 8; i++) begin
            h.wr(5'h02, 8'h01 << i);
            chk("cfg_b_out", 8'h01 << i, {uf, sp, rm, de, isinc, dinv, tinv, qf});
        end
    endtask
    task t_txen;
        logic [1:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 2'(i);
            h.wr(5'h02, {6'h00, v[1], 1'b0});
            @(posedge clock);
            txen_pin <= v[0];
            repeat (4) @(posedge clock);
            #1;
            chk("tx_enable", {7'h00, v[1] ^ v[0]}, {7'h00, txen});
        end
    endtask
    // Frozen write, lock bit not writable, then a reset in mid-run
    task t_freeze_reset;
        logic [7:0] d;
        @(posedge clock);
        ce <= 1'b0;
        h.wr(5'h01, 8'h00);
        chk("frozen_a", 8'hFF, {interp, fm, dmsb, zs});
        @(posedge clock);
        ce <= 1'b1;
        pll_pin <= 1'b0;
        repeat (3) @(posedge clock);
        h.wr(5'h00, 8'h02);
        h.rd(5'h00, d); chk("comm", 8'h00, d);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        h.rd(5'h01, d); chk("cfg_a", 8'h00, d);
        h.rd(5'h02, d); chk("cfg_b", 8'h00, d);
    endtask
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        pll_pin = 1'b0;
        txen_pin = 1'b0;
        pd_req = 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        t_defaults();
        t_comm();
        t_soft();
        t_cfg_a();
        t_cfg_b();
        t_txen();
        t_freeze_reset();
        test_done();
    end
endmodule
`default_nettype wire
